// [irq_ctrl_pkg.sv]
// package: register map, field positions and timing for the dual interrupt output block
`default_nettype none
package irq_ctrl_pkg;
    localparam int ADDR_W = 8;
    // printed offsets (all but 0x30) are not word multiples: they are indices, byte address is four times
    localparam logic [7:0] IDX_LINE_ONE_SELECT = 8'h29;
    localparam logic [7:0] IDX_LINE_TWO_SELECT = 8'h2a;
    localparam logic [7:0] IDX_PIN_CONFIG = 8'h30;
    localparam logic [7:0] IDX_CORRECTION = 8'h31;
    localparam logic [7:0] IDX_FLAGS = 8'h32;
    localparam logic [7:0] IDX_STATUS = 8'h33;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam int BIT_LEVEL = 7;
    localparam int BIT_PERIODIC = 6;
    localparam int BIT_CORRECTION = 5;
    localparam int BIT_ALARM_FIRST = 4;
    localparam int BIT_ALARM_SECOND = 3;
    localparam int BIT_CAPTURE = 2;
    localparam int BIT_SUPPLY_SWAP = 1;
    localparam int BIT_DOG = 0;
    // pin function codes
    localparam logic [1:0] LINE_ONE_FN_IRQ = 2'h0;
    localparam logic [1:0] STAMP_FN_IRQ_TWO = 2'h2;
    localparam logic [1:0] PIN_FN_RESET = 2'h3;
    // correction schedule
    localparam int RUN_MINUTES = 8;
    localparam int SECONDS_PER_MINUTE = 60;
    localparam logic [7:0] CORR_RESET = 8'h00;
    // 128 Hz tick from 50 MHz
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_HZ = 128;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int SECOND_TICKS = TICK_HZ;

    typedef struct packed {
        logic periodic;
        logic alarm_first;
        logic alarm_second;
        logic capture;
        logic supply_swap;
        logic dog;
    } src_events_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

// [dual_interrupt_output_control.sv]
// dual interrupt output control with avalon slave and fast correction schedule
`default_nettype none
module dual_interrupt_output_control
    import irq_ctrl_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire src_events_t src_events,
    input wire logic minute_tick,
    output logic correction_pulse,
    output logic event_monitor_bit,
    output logic irq_line_one_o,
    output logic irq_line_one_oe,
    output logic stamp_pin_o,
    output logic stamp_pin_oe
);
    logic [7:0] irq_line_one_select;
    logic [7:0] irq_line_two_select;
    logic [1:0] irq_line_one_pin_function;
    logic [1:0] stamp_pin_function;
    logic correction_rate_select;
    logic [7:0] correction_amount;
    logic [5:0] flags;
    logic ack;
    logic [31:0] rdata;
    logic err;
    logic [31:0] tick_cnt;
    logic tick;
    logic [2:0] minute_cnt;
    logic [7:0] sec_cnt;
    logic [7:0] pulses_left;
    logic run_active;
    logic [1:0] pulse_hold;
    logic [1:0] tick_seen;

    // index compare shared by the write strobes, the clear path and the error decode
    function automatic logic idx_is(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction : idx_is

    // bus decode
    wire logic req = avs_read | avs_write;
    wire logic access = req & ~ack;
    wire logic [7:0] idx = avs_address[ADDR_W-1:2] == 6'h00 ? 8'h00 : {2'b00, avs_address[ADDR_W-1:2]};
    wire logic wr = avs_write & ack & avs_byteenable[0];
    wire logic hit_one = idx_is(idx, IDX_LINE_ONE_SELECT);
    wire logic hit_two = idx_is(idx, IDX_LINE_TWO_SELECT);
    wire logic hit_pin = idx_is(idx, IDX_PIN_CONFIG);
    wire logic hit_corr = idx_is(idx, IDX_CORRECTION);
    wire logic hit_flag = idx_is(idx, IDX_FLAGS);
    wire logic hit_stat = idx_is(idx, IDX_STATUS);
    wire logic mapped = hit_one | hit_two | hit_pin | hit_corr | hit_flag | hit_stat;

    // one waitstate: request taken at the edge where waitrequest is low
    // back-to-back requests each pay the same single wait cycle
    assign avs_waitrequest = req & ~ack;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= access;
        end
    end

    // readback words assembled once, picked by index below
    wire logic [4:0] pin_word = {correction_rate_select, stamp_pin_function, irq_line_one_pin_function};
    wire logic [11:0] status_word = {event_monitor_bit, run_active, correction_pulse, irq_line_one_o,
        stamp_pin_o, pulses_left[6:0]};

    always_comb begin
        rdata = 32'h0000_0000;
        case (idx)
            IDX_LINE_ONE_SELECT: begin
                rdata[7:0] = irq_line_one_select;
            end
            IDX_LINE_TWO_SELECT: begin
                rdata[7:0] = irq_line_two_select;
            end
            IDX_PIN_CONFIG: begin
                rdata[4:0] = pin_word;
            end
            IDX_CORRECTION: begin
                rdata[7:0] = correction_amount;
            end
            IDX_FLAGS: begin
                rdata[5:0] = flags;
            end
            IDX_STATUS: begin
                rdata[11:0] = status_word;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data latched in the wait cycle so it stands from a flop when waitrequest drops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (access) begin
            avs_readdata <= rdata;
        end
    end
    assign avs_response_err = ack & ~mapped;
    assign err = avs_response_err;

    // write strobes: byte lane 0, accepting edge, mapped index only
    wire logic wr_ok = wr & ~err;
    wire logic wr_one = wr_ok & hit_one;
    wire logic wr_two = wr_ok & hit_two;
    wire logic wr_pin = wr_ok & hit_pin;
    wire logic wr_corr = wr_ok & hit_corr;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_line_one_select <= SELECT_RESET;
        end else if (wr_one) begin
            irq_line_one_select <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_line_two_select <= SELECT_RESET;
        end else if (wr_two) begin
            irq_line_two_select <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_line_one_pin_function <= PIN_FN_RESET;
            stamp_pin_function <= PIN_FN_RESET;
            correction_rate_select <= 1'b0;
        end else if (wr_pin) begin
            irq_line_one_pin_function <= avs_writedata[1:0];
            stamp_pin_function <= avs_writedata[3:2];
            correction_rate_select <= avs_writedata[4];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            correction_amount <= CORR_RESET;
        end else if (wr_corr) begin
            correction_amount <= avs_writedata[7:0];
        end
    end

    // sticky flags: write one to clear, a new event wins over the clear
    wire logic [5:0] events = {src_events.periodic, src_events.alarm_first, src_events.alarm_second,
        src_events.capture, src_events.supply_swap, src_events.dog};
    wire logic [5:0] clr = (wr & hit_flag) ? avs_writedata[5:0] : 6'h00;

    // value the flags take at this edge, so an early pulse release sees the clear at once
    wire logic [5:0] next_flags = (flags & ~clr) | events;

    generate
        for (genvar f = 0; f < 6; f++) begin : g_flag
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    flags[f] <= 1'b0;
                end else if (events[f]) begin
                    flags[f] <= 1'b1;
                end else if (clr[f]) begin
                    flags[f] <= 1'b0;
                end
            end
        end
    endgenerate

    assign event_monitor_bit = |flags;

    // free-running 128 Hz tick, not aligned to any event
    // so a pulse lasts anywhere from one to two tick periods
    wire logic tick_wrap = tick_cnt >= 32'(TICK_DIV - 1);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_cnt <= 32'h0000_0000;
        end else if (tick_wrap) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end
    assign tick = tick_cnt == 32'(TICK_DIV - 1);

    // fast correction: magnitude pulses, one a second, from second 00 of every eighth minute
    // only the fast grid is scheduled; the slow four-hour grid is not built here
    typedef enum {RUN_IDLE, RUN_BUSY} run_state_t;
    run_state_t run_state;
    wire logic [7:0] magnitude = correction_amount[7] ? 8'(-correction_amount) : correction_amount;
    wire logic sec_wrap = sec_cnt == 8'(SECOND_TICKS - 1);
    wire logic minute_last = minute_cnt == 3'(RUN_MINUTES - 1);
    wire logic run_start = correction_rate_select & minute_tick & minute_last & (magnitude != 8'h00);
    wire logic run_last = pulses_left == 8'h00;
    wire logic [7:0] next_sec = sec_wrap ? 8'h00 : sec_cnt + 8'h01;

    assign run_active = run_state == RUN_BUSY;

    // minute count runs in both modes so a mode switch keeps the eight-minute grid
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            minute_cnt <= 3'h0;
        end else if (minute_tick) begin
            minute_cnt <= minute_cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_state <= RUN_IDLE;
            sec_cnt <= 8'h00;
            pulses_left <= 8'h00;
            correction_pulse <= 1'b0;
        end else begin
            correction_pulse <= 1'b0;
            case (run_state)
                RUN_IDLE: begin
                    if (run_start) begin
                        // first pulse at second 00, larger values spill into following minutes
                        run_state <= RUN_BUSY;
                        pulses_left <= magnitude - 8'h01;
                        sec_cnt <= 8'h00;
                        correction_pulse <= 1'b1;
                    end
                end
                RUN_BUSY: begin
                    if (~correction_rate_select) begin
                        run_state <= RUN_IDLE;
                    end else if (tick) begin
                        sec_cnt <= next_sec;
                        if (sec_wrap & run_last) begin
                            run_state <= RUN_IDLE;
                        end else if (sec_wrap) begin
                            pulses_left <= pulses_left - 8'h01;
                            correction_pulse <= 1'b1;
                        end
                    end
                end
                default: begin
                    run_state <= RUN_IDLE;
                end
            endcase
        end
    end

    // per-line trigger vector in select bit order 6..0
    wire logic [6:0] trig = {src_events.periodic, correction_pulse, src_events.alarm_first,
        src_events.alarm_second, src_events.capture, src_events.supply_swap, src_events.dog};
    wire logic [6:0] flag_vec = {flags[5], 1'b0, flags[4:0]};
    wire logic [6:0] next_flag_vec = {next_flags[5], 1'b0, next_flags[4:0]};

    // pulse hold: asserted with the trigger, released after the second 128 Hz tick
    genvar g;
    logic [1:0] line_active;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            wire logic [7:0] sel = g == 0 ? irq_line_one_select : irq_line_two_select;
            wire logic [6:0] trig_on = trig & sel[6:0];
            wire logic [6:0] flags_on = flag_vec & sel[6:0];
            wire logic [6:0] next_on = next_flag_vec & sel[6:0];
            wire logic fire = |trig_on;
            wire logic level = |flags_on;
            // correction has no flag to clear, so its pulse always runs the full tick time
            wire logic flag_gone = ~|next_on & ~(sel[BIT_CORRECTION] & pulse_hold[g]);
            wire logic clear_now = (clr != 6'h00) & flag_gone;
            wire logic release_now = tick & tick_seen[g];

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    pulse_hold[g] <= 1'b0;
                    tick_seen[g] <= 1'b0;
                end else if (fire) begin
                    pulse_hold[g] <= 1'b1;
                    tick_seen[g] <= 1'b0;
                end else if (pulse_hold[g]) begin
                    if (release_now) begin
                        pulse_hold[g] <= 1'b0;
                    end
                    if (tick) begin
                        tick_seen[g] <= 1'b1;
                    end
                    // pulse dropped early when a flag clear write leaves no enabled flag set and the line does not select correction
                    if (clear_now) begin
                        pulse_hold[g] <= 1'b0;
                    end
                end
            end

            // pulse shows in the trigger cycle itself
            assign line_active[g] = sel[BIT_LEVEL] ? level : (fire | pulse_hold[g]);
        end
    endgenerate

    // line one open drain: drive low only, a released line rests on the host pull-up
    wire logic one_on = irq_line_one_pin_function == LINE_ONE_FN_IRQ;
    wire logic one_pull = one_on & line_active[0];
    assign irq_line_one_o = 1'b0;
    assign irq_line_one_oe = one_pull;

    // line two push-pull on stamp pin, high when idle
    // pin stays undriven until software selects the interrupt function
    wire logic two_on = stamp_pin_function == STAMP_FN_IRQ_TWO;
    wire logic two_low = line_active[1];
    assign stamp_pin_oe = two_on;
    assign stamp_pin_o = ~two_low;
endmodule : dual_interrupt_output_control
`default_nettype wire

// [dual_interrupt_output_control_asserts.sv]
// port checker for the dual interrupt output block
`default_nettype none
module irq_ctrl_asserts
    import irq_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    input wire src_events_t src_events,
    input wire logic correction_pulse,
    input wire logic event_monitor_bit,
    input wire logic irq_line_one_o,
    input wire logic irq_line_one_oe,
    input wire logic stamp_pin_o,
    input wire logic stamp_pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_line_one_drain: assert property (!irq_line_one_o) else $error("line one driven high");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait state");
    a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
    a_err_answer: assert property (avs_response_err |-> (avs_read || avs_write) && !avs_waitrequest)
        else $error("stray error");
    a_err_readzero: assert property (avs_read && avs_response_err |-> avs_readdata == 32'h0)
        else $error("error read not zero");
    a_flag_monitor: assert property (src_events != '0 |=> event_monitor_bit) else $error("monitor low");
    a_corr_single: assert property (correction_pulse |=> !correction_pulse [*8]) else $error("pulse run");
    a_pin_steady: assert property ($stable(stamp_pin_oe) || $past(avs_write && !avs_waitrequest))
        else $error("stamp pin mode moved");
    a_reset_quiet: assert property ($past(reset) |-> !stamp_pin_oe && !irq_line_one_oe)
        else $error("pin active after reset");
    c_corr: cover property (correction_pulse);
    c_err: cover property (avs_response_err);
    c_two_low: cover property ($fell(stamp_pin_o));
endmodule : irq_ctrl_asserts
bind dual_interrupt_output_control irq_ctrl_asserts chk_u (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .avs_response_err, .src_events, .correction_pulse,
    .event_monitor_bit, .irq_line_one_o, .irq_line_one_oe, .stamp_pin_o, .stamp_pin_oe);
`default_nettype wire

// [irq_host_model.sv]
// host side model of the two interrupt input lines
`default_nettype none
module irq_host_model (
    input wire logic sys_clk,
    input wire logic line_one_oe,
    input wire logic stamp_o,
    input wire logic stamp_oe,
    output logic line_one_n,
    output logic line_two_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_q = 1'h0;
    // undriven push-pull pin has no pull: toggle so a stale high cannot pass
    always @(posedge sys_clk) float_q <= !float_q;
    assign line_one_n = line_one_oe ? 1'h0 : 1'h1;
    assign line_two_n = stamp_oe ? stamp_o : float_q;
endmodule : irq_host_model
`default_nettype wire

// [dual_interrupt_output_control_tb.sv]
// self-checking bench for the dual interrupt output block
`default_nettype none
module dual_interrupt_output_control_tb;
    import irq_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TD = 20;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_t;
    row_t rows [8] = '{'{1'h0, 8'ha4, 8'h00, 8'h00, 1'h0}, '{1'h0, 8'ha8, 8'h00, 8'h00, 1'h0},
        '{1'h0, 8'h00, 8'h00, 8'h00, 1'h1}, '{1'h1, 8'ha4, 8'h5a, 8'h00, 1'h0},
        '{1'h0, 8'ha4, 8'h00, 8'h5a, 1'h0}, '{1'h0, 8'ha8, 8'h00, 8'h00, 1'h0},
        '{1'h1, 8'h00, 8'hff, 8'h00, 1'h1}, '{1'h1, 8'ha4, 8'h00, 8'h00, 1'h0}};
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic minute_tick = 1'h0;
    src_events_t ev = '0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, avs_response_err, correction_pulse, event_monitor_bit, e;
    logic irq_line_one_o, irq_line_one_oe, stamp_pin_o, stamp_pin_oe, line_one_n, line_two_n;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int np = 0;
    int n;
    dual_interrupt_output_control #(.TICK_DIV(TD)) dut_u (.sys_clk, .reset, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err,
        .src_events(ev), .minute_tick, .correction_pulse, .event_monitor_bit, .irq_line_one_o,
        .irq_line_one_oe, .stamp_pin_o, .stamp_pin_oe);
    irq_host_model host_u (.sys_clk, .line_one_oe(irq_line_one_oe), .stamp_o(stamp_pin_o),
        .stamp_oe(stamp_pin_oe), .line_one_n, .line_two_n);
    always #10 sys_clk = !sys_clk;
    task conclude;
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        @(posedge sys_clk);
        while (avs_waitrequest) @(posedge sys_clk);
        q = avs_readdata;
        e = avs_response_err;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge sys_clk);
    endtask : bus
    // one-cycle event, returns on the edge after it so flags have landed
    task ev1(input src_events_t s);
        ev <= s;
        @(posedge sys_clk);
        ev <= '0;
        @(posedge sys_clk);
    endtask : ev1
    // width in cycles of the line one pulse, zero if it did not start in the event cycle
    task pulse_w(input src_events_t s);
        ev <= s;
        #1;
        n = 0;
        while (!line_one_n && n < 99) begin
            @(posedge sys_clk);
            ev <= '0;
            #1;
            n++;
        end
        ev <= '0;
        @(posedge sys_clk);
    endtask : pulse_w
    always @(posedge sys_clk) begin
        cyc++;
        if (correction_pulse) begin
            np++;
            chk({line_one_n, line_two_n}, 2'h1);
        end
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        chk({stamp_pin_oe, irq_line_one_oe}, 2'h0);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(q, {24'h0, rows[i].q});
            chk(e, rows[i].e);
        end
        bus(1'h1, 8'hc0, 8'h08);
        chk(line_two_n, 1'h1);
        bus(1'h1, 8'ha4, 8'h04);
        bus(1'h1, 8'ha8, 8'h82);
        // second capture finds its flag still set
        for (int k = 0; k < 2; k++) begin
            pulse_w(6'h04);
            chk(n inside {[TD - 1:2 * TD + 1]}, 1'h1);
        end
        ev1(6'h04);
        bus(1'h1, 8'hc8, 8'h3f);
        chk(line_one_n, 1'h1);
        ev1(6'h20);
        chk({line_one_n, line_two_n, event_monitor_bit}, 3'h7);
        ev1(6'h02);
        repeat (3 * TD) @(posedge sys_clk);
        chk({line_one_n, line_two_n}, 2'h2);
        bus(1'h1, 8'hc8, 8'h3f);
        chk({line_two_n, event_monitor_bit}, 2'h2);
        bus(1'h1, 8'hc4, 8'h02);
        bus(1'h1, 8'hc0, 8'h18);
        bus(1'h1, 8'ha4, 8'h20);
        bus(1'h1, 8'ha8, 8'ha0);
        repeat (8) begin
            minute_tick <= 1'h1;
            @(posedge sys_clk);
            minute_tick <= 1'h0;
            repeat (9) @(posedge sys_clk);
        end
        repeat (3 * 128 * TD) @(posedge sys_clk);
        chk(np, 2);
        conclude();
    end
endmodule : dual_interrupt_output_control_tb
`default_nettype wire
